// ==== rtl/dio_defs.svh ====
`ifndef FRONT_LINE_DEFS_SVH
`define FRONT_LINE_DEFS_SVH

`define LINE_COUNT 14
`define ADDR_WIDTH 12
`define FILTER_WIDTH 16

`define LEVEL_STATUS_OFFSET 12'h354
`define FILTER_CONFIG_OFFSET 12'h358
`define DRIVE_VALUE_OFFSET 12'h35C
`define TX_ENABLE_OFFSET 12'h360

`define FILTER_RESET 16'h0000
`define LINE_RESET 14'h0000
`define ROUTE_FRONT 2'h3

`define CLK_PERIOD_NS 10
`define TICK_NS 50
`define TICK_CYCLES ((`TICK_NS + `CLK_PERIOD_NS - 1) / `CLK_PERIOD_NS)
`define TICK_LAST 3'(`TICK_CYCLES - 1)

`endif

// ==== rtl/dio_pkg.sv ====
`include "dio_defs.svh"
package front_line_pkg;
	typedef logic [`LINE_COUNT-1:0] line_vec_t;
	typedef logic [`FILTER_WIDTH-1:0] filter_t;

	typedef struct packed {
		logic write;
		logic read;
		logic [`ADDR_WIDTH-1:0] addr;
		logic [31:0] writeData;
	} reg_req_s;

	typedef struct packed {
		logic valid;
		logic [31:0] data;
	} reg_rsp_s;

	typedef struct packed {
		logic [1:0] clk1Route;
		logic [1:0] clk2Route;
		logic [1:0] trigRoute;
		logic convClk1;
		logic convClk2;
		logic frameTrig;
	} conv_route_s;
endpackage

// ==== rtl/level_sync.sv ====
`timescale 1ns/100ps
`include "dio_defs.svh"
module level_sync import front_line_pkg::*; (
	// Clock and reset
	input wire logic sys_clk,
	input wire logic reset,
	// Levels
	input wire line_vec_t asyncLevel,
	output line_vec_t syncLevel
);
	line_vec_t firstStage;
	line_vec_t next_firstStage;
	line_vec_t next_syncLevel;

	// First stage feeds only the second stage
	always_comb begin
		next_firstStage = asyncLevel;
		next_syncLevel = firstStage;
	end

	always_ff @(posedge sys_clk) begin
		if (reset) begin
			firstStage <= `LINE_RESET;
			syncLevel <= `LINE_RESET;
		end else begin
			firstStage <= next_firstStage;
			syncLevel <= next_syncLevel;
		end
	end
endmodule // level_sync

// ==== rtl/bounce_filter_line.sv ====
`timescale 1ns/100ps
`include "dio_defs.svh"
module bounce_filter_line import front_line_pkg::*; (
	// Clock and reset
	input wire logic sys_clk,
	input wire logic reset,
	// Filter
	input wire logic syncLevel,
	input wire filter_t filterCount,
	output logic filtered
);
	logic [2:0] subTick;
	filter_t ticks;
	logic next_filtered;
	logic [2:0] next_subTick;
	filter_t next_ticks;
	logic atThreshold;

	// Tick phase restarts whenever the level matches the filtered output, so the stable time is exact in cycles
	// Lowering the field mid-count must not leave a line waiting for the count to wrap
	assign atThreshold = (subTick == `TICK_LAST) && (ticks >= filterCount);

	always_comb begin
		next_filtered = filtered;
		next_subTick = 3'h0;
		next_ticks = 16'h0000;
		if (syncLevel != filtered) begin
			if (atThreshold) begin
				next_filtered = syncLevel;
			end else if (subTick == `TICK_LAST) begin
				next_ticks = ticks + 16'h0001;
			end else begin
				next_subTick = subTick + 3'h1;
				next_ticks = ticks;
			end
		end
	end

	always_ff @(posedge sys_clk) begin
		if (reset) begin
			filtered <= 1'b0;
			subTick <= 3'h0;
			ticks <= 16'h0000;
		end else begin
			filtered <= next_filtered;
			subTick <= next_subTick;
			ticks <= next_ticks;
		end
	end

	default clocking cb @(posedge sys_clk); endclocking
	default disable iff (reset);

	sequence mismatchAtLimit;
		(syncLevel != filtered) && atThreshold;
	endsequence

	filter_change_a: assert property ($changed(filtered) |-> $past(atThreshold) &&
		$past(syncLevel != filtered))
		else $error("filtered level changed before the stability time");
	filter_pass_a: assert property (mismatchAtLimit |=> filtered == $past(syncLevel))
		else $error("stable level was not forwarded at the stability time");
	filter_restart_a: assert property ((syncLevel == filtered) |=>
		subTick == 3'h0 && ticks == 16'h0000)
		else $error("stability counter did not restart on a matching level");
endmodule // bounce_filter_line

// ==== rtl/debounced_digital_io_port.sv ====
`timescale 1ns/100ps
`include "dio_defs.svh"
module debounced_digital_io_port import front_line_pkg::*; (
	// Clock and reset
	input wire logic sys_clk,
	input wire logic reset,
	// Register access from the host link
	input wire reg_req_s regReq,
	output reg_rsp_s regRsp,
	// Conversion signals routed to lines 1, 3 and 5
	input wire conv_route_s convRoute,
	// Front panel lines
	input wire line_vec_t linePin,
	output line_vec_t lineDrive,
	output line_vec_t lineDriveEnable,
	// Debounced levels for internal logic
	output line_vec_t filteredLevel
);
	line_vec_t syncLevel;
	line_vec_t filteredWire;
	line_vec_t driveValue;
	line_vec_t txEnable;
	filter_t bounceFilterCount;
	line_vec_t next_driveValue;
	line_vec_t next_txEnable;
	filter_t next_bounceFilterCount;
	reg_rsp_s next_regRsp;
	line_vec_t next_lineDrive;
	line_vec_t next_lineDriveEnable;
	line_vec_t routeDrive;
	line_vec_t routeMask;

	level_sync pinSync (
		.sys_clk(sys_clk),
		.reset(reset),
		.asyncLevel(linePin),
		.syncLevel(syncLevel)
	);

	genvar lineIdx;
	generate
		for (lineIdx = 0; lineIdx < `LINE_COUNT; lineIdx++) begin : lineFilter
			bounce_filter_line filterUnit (
				.sys_clk(sys_clk),
				.reset(reset),
				.syncLevel(syncLevel[lineIdx]),
				.filterCount(bounceFilterCount),
				.filtered(filteredWire[lineIdx])
			);
		end
	endgenerate

	// Register writes; bits above each field are dropped
	always_comb begin
		next_driveValue = driveValue;
		next_txEnable = txEnable;
		next_bounceFilterCount = bounceFilterCount;
		if (regReq.write) begin
			if (regReq.addr == `FILTER_CONFIG_OFFSET) begin
				next_bounceFilterCount = regReq.writeData[`FILTER_WIDTH-1:0];
			end else if (regReq.addr == `DRIVE_VALUE_OFFSET) begin
				next_driveValue = regReq.writeData[`LINE_COUNT-1:0];
			end else if (regReq.addr == `TX_ENABLE_OFFSET) begin
				next_txEnable = regReq.writeData[`LINE_COUNT-1:0];
			end
		end
	end

	// Register reads; unmapped addresses answer zero
	always_comb begin
		next_regRsp.valid = regReq.read;
		next_regRsp.data = 32'h00000000;
		if (regReq.read) begin
			if (regReq.addr == `LEVEL_STATUS_OFFSET) begin
				next_regRsp.data = {18'h00000, syncLevel};
			end else if (regReq.addr == `FILTER_CONFIG_OFFSET) begin
				next_regRsp.data = {16'h0000, bounceFilterCount};
			end else if (regReq.addr == `DRIVE_VALUE_OFFSET) begin
				next_regRsp.data = {18'h00000, driveValue};
			end else if (regReq.addr == `TX_ENABLE_OFFSET) begin
				next_regRsp.data = {18'h00000, txEnable};
			end
		end
	end

	// Front route code on lines 1, 3 and 5 only; other codes leave the pin alone
	always_comb begin
		routeDrive = `LINE_RESET;
		routeMask = `LINE_RESET;
		routeDrive[0] = convRoute.convClk1;
		routeDrive[2] = convRoute.convClk2;
		routeDrive[4] = convRoute.frameTrig;
		routeMask[0] = (convRoute.clk1Route == `ROUTE_FRONT);
		routeMask[2] = (convRoute.clk2Route == `ROUTE_FRONT);
		routeMask[4] = (convRoute.trigRoute == `ROUTE_FRONT);
	end

	// Register value wins over a routed signal wherever the transmitter is enabled
	always_comb begin
		next_lineDriveEnable = txEnable | routeMask;
		next_lineDrive = (txEnable & driveValue) | (~txEnable & routeMask & routeDrive);
	end

	always_ff @(posedge sys_clk) begin
		if (reset) begin
			bounceFilterCount <= `FILTER_RESET;
			driveValue <= `LINE_RESET;
			txEnable <= `LINE_RESET;
			regRsp <= '0;
			lineDrive <= `LINE_RESET;
			lineDriveEnable <= `LINE_RESET;
			filteredLevel <= `LINE_RESET;
		end else begin
			bounceFilterCount <= next_bounceFilterCount;
			driveValue <= next_driveValue;
			txEnable <= next_txEnable;
			regRsp <= next_regRsp;
			lineDrive <= next_lineDrive;
			lineDriveEnable <= next_lineDriveEnable;
			filteredLevel <= filteredWire;
		end
	end

	default clocking cb @(posedge sys_clk); endclocking

	sequence statusRead;
		regReq.read && regReq.addr == `LEVEL_STATUS_OFFSET;
	endsequence

	sequence enableWrite;
		regReq.write && regReq.addr == `TX_ENABLE_OFFSET;
	endsequence

	reset_state_a: assert property (@(posedge sys_clk) reset |=>
		txEnable == 14'h0000 && lineDriveEnable == 14'h0000)
		else $error("transmitters not disabled after reset");
	reset_fields_a: assert property (@(posedge sys_clk) reset |=>
		bounceFilterCount == 16'h0000 && driveValue == 14'h0000)
		else $error("filter or drive value not cleared by reset");
	status_level_a: assert property (disable iff (reset) statusRead |=>
		regRsp.valid && regRsp.data[13:0] == $past(syncLevel))
		else $error("status read does not show the pin level");
	status_driven_a: assert property (disable iff (reset)
		(statusRead ##0 (txEnable[0] && syncLevel[0])) |=> regRsp.data[0])
		else $error("driven high line does not read back as one");
	reserved_zero_a: assert property (disable iff (reset) regRsp.valid |->
		regRsp.data[31:16] == 16'h0000)
		else $error("reserved bits read nonzero");
	enable_drive_a: assert property (disable iff (reset) enableWrite ##1 1'b1 |=>
		lineDriveEnable[13:0] == ($past(regReq.writeData[13:0], 2) | $past(routeMask)))
		else $error("pin enable does not follow the transmitter enable write");
	value_wins_a: assert property (disable iff (reset) 1'b1 |=>
		(lineDrive & $past(txEnable)) == ($past(driveValue) & $past(txEnable)))
		else $error("enabled line not driven from its value bit");
	input_undriven_a: assert property (disable iff (reset) 1'b1 |=>
		(lineDriveEnable & ~$past(txEnable) & ~$past(routeMask)) == 14'h0000)
		else $error("line configured as input is driven");
	route_pass_a: assert property (disable iff (reset)
		(convRoute.clk1Route == `ROUTE_FRONT && !txEnable[0]) |=>
		lineDriveEnable[0] && lineDrive[0] == $past(convRoute.convClk1))
		else $error("routed conversion clock missing from line one");
	drive_level_a: assert property (disable iff (reset) (txEnable[3] && driveValue[3]) |=>
		lineDrive[3] && lineDriveEnable[3])
		else $error("drive value one not driven high");
endmodule // debounced_digital_io_port

// ==== bench/ttl_line_partner.sv ====
`timescale 1ns/100ps
`include "dio_defs.svh"
module ttl_line_partner import front_line_pkg::*; (
	// Clock
	input wire logic sys_clk,
	// Module side of the lines
	input wire line_vec_t lineDrive,
	input wire line_vec_t lineDriveEnable,
	// External devices
	input wire line_vec_t extLevel,
	input wire line_vec_t extEnable,
	// Resolved pins
	output line_vec_t linePin
);
	line_vec_t lastPin;
	// Remember only driven levels, so a floating line settles instead of toggling
	always_ff @(posedge sys_clk) begin
		for (int i = 0; i < `LINE_COUNT; i++) begin
			if (lineDriveEnable[i] || extEnable[i]) begin
				lastPin[i] <= linePin[i];
			end
		end
	end
	// No pull resistors: an undriven line shows the inverse of its last driven level
	always_comb begin
		for (int i = 0; i < `LINE_COUNT; i++) begin
			if (lineDriveEnable[i]) begin
				linePin[i] = lineDrive[i];
			end else if (extEnable[i]) begin
				linePin[i] = extLevel[i];
			end else begin
				linePin[i] = ~lastPin[i];
			end
		end
	end
endmodule // ttl_line_partner

// ==== bench/debounced_digital_io_port_tb.sv ====
`timescale 1ns/100ps
`include "dio_defs.svh"
module debounced_digital_io_port_tb import front_line_pkg::*;;
	logic sys_clk = 1'b0;
	logic reset = 1'b1;
	reg_req_s regReq = '0;
	reg_rsp_s regRsp;
	conv_route_s convRoute = '0;
	line_vec_t linePin, lineDrive, lineDriveEnable, filteredLevel;
	line_vec_t extLevel = '0;
	line_vec_t extEnable = '1;
	int err_total = 0;
	int checks = 0;
	int cycles = 0;
	debounced_digital_io_port dut_u (.sys_clk(sys_clk), .reset(reset), .regReq(regReq),
		.regRsp(regRsp), .convRoute(convRoute), .linePin(linePin), .lineDrive(lineDrive),
		.lineDriveEnable(lineDriveEnable), .filteredLevel(filteredLevel));
	ttl_line_partner peer_u (.sys_clk(sys_clk), .lineDrive(lineDrive),
		.lineDriveEnable(lineDriveEnable), .extLevel(extLevel), .extEnable(extEnable),
		.linePin(linePin));
	initial begin
		forever #5 sys_clk = ~sys_clk;
	end
	task automatic finish_test();
		$display("checks=%0d err_total=%0d", checks, err_total);
		if (err_total == 0 && checks > 0) begin
			$display("bench passed");
		end else begin
			$display("bench failed");
		end
		$finish;
	endtask
	// Hang guard sized well above the longest scenario
	always @(posedge sys_clk) begin
		cycles++;
		if (cycles == 5000) begin
			err_total++;
			finish_test();
		end
	end
	task automatic chk(input logic [31:0] got, input logic [31:0] exp);
		checks++;
		if (got !== exp) begin
			$display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp);
			err_total++;
		end
	endtask
	task automatic ticks(input int n);
		repeat (n) @(posedge sys_clk);
		#1;
	endtask
	task automatic reg_write(input logic [11:0] a, input logic [31:0] d);
		@(posedge sys_clk);
		regReq <= '{1'b1, 1'b0, a, d};
		@(posedge sys_clk);
		regReq <= '0;
	endtask
	// Answer is registered, so it is looked at just after the taking edge
	task automatic rd_chk(input logic [11:0] a, input logic [31:0] exp);
		@(posedge sys_clk);
		regReq <= '{1'b0, 1'b1, a, 32'h0000_0000};
		@(posedge sys_clk);
		regReq <= '0;
		#1;
		chk(regRsp.valid ? regRsp.data : 32'hXXXX_XXXX, exp);
	endtask
	task automatic test_reset();
		chk(lineDriveEnable, 14'h0000);
		rd_chk(`FILTER_CONFIG_OFFSET, 32'h0000_0000);
		rd_chk(`DRIVE_VALUE_OFFSET, 32'h0000_0000);
		rd_chk(`TX_ENABLE_OFFSET, 32'h0000_0000);
		rd_chk(`LEVEL_STATUS_OFFSET, 32'h0000_0000);
	endtask
	task automatic test_reserved();
		reg_write(`DRIVE_VALUE_OFFSET, 32'hFFFF_FFFF);
		reg_write(`FILTER_CONFIG_OFFSET, 32'hFFFF_FFFF);
		reg_write(`LEVEL_STATUS_OFFSET, 32'hFFFF_FFFF);
		rd_chk(`DRIVE_VALUE_OFFSET, 32'h0000_3FFF);
		rd_chk(`FILTER_CONFIG_OFFSET, 32'h0000_FFFF);
		rd_chk(`LEVEL_STATUS_OFFSET, 32'h0000_0000);
		rd_chk(12'h364, 32'h0000_0000);
		reg_write(`FILTER_CONFIG_OFFSET, 32'h0000_0000);
	endtask
	task automatic test_drive();
		extLevel <= 14'h1555;
		reg_write(`DRIVE_VALUE_OFFSET, 32'h0000_2A55);
		ticks(2);
		chk(lineDriveEnable, 14'h0000);
		chk(linePin, 14'h1555);
		extEnable <= '0;
		reg_write(`TX_ENABLE_OFFSET, 32'h0000_3FFF);
		ticks(2);
		chk(lineDrive, 14'h2A55);
		chk(lineDriveEnable, 14'h3FFF);
		ticks(3);
		rd_chk(`LEVEL_STATUS_OFFSET, 32'h0000_2A55);
		extEnable <= '1;
		reg_write(`TX_ENABLE_OFFSET, 32'h0000_0000);
		ticks(2);
		chk(lineDriveEnable, 14'h0000);
	endtask
	task automatic test_status();
		extLevel <= 14'h2C93;
		ticks(4);
		rd_chk(`LEVEL_STATUS_OFFSET, 32'h0000_2C93);
		extLevel <= 14'h0000;
		ticks(40);
	endtask
	// Field 1 gives a stable span of 10 cycles; pass time is 13 cycles
	task automatic test_filter();
		reg_write(`FILTER_CONFIG_OFFSET, 32'h0000_0001);
		@(posedge sys_clk);
		extLevel <= 14'h2000;
		repeat (9) @(posedge sys_clk);
		extLevel <= 14'h0000;
		for (int i = 0; i < 20; i++) begin
			ticks(1);
			chk(filteredLevel, 14'h0000);
		end
		@(posedge sys_clk);
		extLevel <= 14'h2001;
		ticks(8);
		chk(filteredLevel, 14'h0000);
		ticks(12);
		chk(filteredLevel, 14'h2001);
		extLevel <= 14'h0000;
		ticks(20);
		chk(filteredLevel, 14'h0000);
	endtask
	task automatic test_route();
		extEnable <= ~14'h0015;
		convRoute <= '{2'h3, 2'h3, 2'h3, 1'b1, 1'b1, 1'b1};
		ticks(3);
		chk(lineDrive & lineDriveEnable & 14'h0015, 14'h0015);
		reg_write(`DRIVE_VALUE_OFFSET, 32'h0000_0000);
		reg_write(`TX_ENABLE_OFFSET, 32'h0000_0015);
		ticks(2);
		chk(lineDrive & 14'h0015, 14'h0000);
		reg_write(`TX_ENABLE_OFFSET, 32'h0000_0000);
		convRoute <= '{2'h2, 2'h2, 2'h2, 1'b1, 1'b1, 1'b1};
		ticks(3);
		chk(lineDriveEnable, 14'h0000);
		extEnable <= '1;
	endtask
	initial begin
		repeat (4) @(posedge sys_clk);
		reset <= 1'b0;
		ticks(1);
		test_reset();
		test_reserved();
		test_drive();
		test_status();
		test_filter();
		test_route();
		finish_test();
	end
endmodule // debounced_digital_io_port_tb
